// ===== src/dcs_channel_status.sv
// Per-channel status register bank with AXI4-Lite slave
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_map.svh"
module dcs_channel_status (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Engine events
  input  wire logic        error_event,
  input  wire logic        peer_error_event,
  input  wire logic        desc_done,
  input  wire logic        desc_eof,
  input  wire logic        pkt_arrive,
  input  wire logic        last_beat,
  input  wire logic        queue_drained,
  // Engine controls
  output logic             channel_run_bit,
  output logic             fetch_start,
  output logic             pkt_discard,
  output logic             irq_out
);

  dcs_pkg::dcs_state_s st_reg;
  dcs_pkg::dcs_state_s st_next;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic dcs_pkg::dcs_sel_e dcs_decode(input logic [3:0] addr);
    case (addr)
      `DCS_OFF_CTRL:   dcs_decode = dcs_pkg::DCS_SEL_CTRL;
      `DCS_OFF_STATUS: dcs_decode = dcs_pkg::DCS_SEL_STATUS;
      `DCS_OFF_TAIL:   dcs_decode = dcs_pkg::DCS_SEL_TAIL;
      default:         dcs_decode = dcs_pkg::DCS_SEL_NONE;
    endcase
  endfunction

  function automatic logic [31:0] dcs_merge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    dcs_merge = m;
  endfunction

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h00000000;
    status_word[`DCS_F_CNT0_HI:`DCS_F_CNT0_LO] = st_reg.dly_cnt;
    status_word[`DCS_F_CNT1_HI:`DCS_F_CNT1_LO] = st_reg.cmp_cnt;
    status_word[`DCS_F_CNT2_HI:`DCS_F_CNT2_LO] = st_reg.drp_cnt;
    status_word[`DCS_F_ERR:`DCS_F_PEER] = st_reg.flags;
    status_word[`DCS_F_SHORT] = st_reg.shortfall;
    status_word[`DCS_F_IDLE] = st_reg.idle;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic        wr_go;
  logic        rd_go;
  logic        tick;
  logic        accept_pkt;
  logic        cmp_evt;
  logic        drp_evt;
  logic [4:0]  clr;
  logic [4:0]  set;
  logic [31:0] wval;
  dcs_pkg::dcs_sel_e wsel;

  always_comb begin
    st_next = st_reg;
    st_next.fetch = 1'b0;
    st_next.discard = 1'b0;
    wsel = dcs_decode(st_reg.aw_addr);
    wr_go = st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid;
    rd_go = s_axi_arvalid && !st_reg.rvalid;
    wval = 32'h00000000;
    clr = 5'h00;

    // Address and data taken in either order, held until commit
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_hold = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_hold = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_next.aw_hold = 1'b0;
      st_next.w_hold = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = `DCS_RESP_OKAY;
      case (wsel)
        dcs_pkg::DCS_SEL_CTRL: begin
          wval = dcs_merge(st_reg.ctrl, st_reg.w_data, st_reg.w_strb);
          // Zero thresholds are not accepted
          if (wval[`DCS_F_CNT1_HI:`DCS_F_CNT1_LO] == `DCS_CNT_ZERO) begin
            wval[`DCS_F_CNT1_HI:`DCS_F_CNT1_LO] = st_reg.ctrl[`DCS_F_CNT1_HI:`DCS_F_CNT1_LO];
          end
          if (wval[`DCS_F_CNT2_HI:`DCS_F_CNT2_LO] == `DCS_CNT_ZERO) begin
            wval[`DCS_F_CNT2_HI:`DCS_F_CNT2_LO] = st_reg.ctrl[`DCS_F_CNT2_HI:`DCS_F_CNT2_LO];
          end
          wval[`DCS_F_RSV_HI:`DCS_F_RSV_LO] = 2'h0;
          st_next.ctrl = wval;
        end
        dcs_pkg::DCS_SEL_STATUS: begin
          // Only the flag byte is writable
          if (st_reg.w_strb[0]) begin
            clr = st_reg.w_data[`DCS_F_ERR:`DCS_F_PEER];
          end
        end
        dcs_pkg::DCS_SEL_TAIL: begin
          wval = dcs_merge(st_reg.tail, st_reg.w_data, st_reg.w_strb);
          st_next.tail = wval & `DCS_TAIL_MASK;
          if (st_reg.ctrl[`DCS_F_RUN] && st_reg.idle) begin
            st_next.fetch = 1'b1;
          end
        end
        default: begin
          st_next.bresp = `DCS_RESP_SLVERR;
        end
      endcase
    end

    // Read channel
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (rd_go) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = `DCS_RESP_OKAY;
      case (dcs_decode(s_axi_araddr))
        dcs_pkg::DCS_SEL_CTRL:   st_next.rdata = st_reg.ctrl;
        dcs_pkg::DCS_SEL_STATUS: st_next.rdata = status_word;
        dcs_pkg::DCS_SEL_TAIL:   st_next.rdata = st_reg.tail;
        default: begin
          st_next.rdata = 32'h00000000;
          st_next.rresp = `DCS_RESP_SLVERR;
        end
      endcase
    end

    // Packet intake; idle channel throws packets away
    accept_pkt = pkt_arrive && !st_reg.idle;
    drp_evt = pkt_arrive && st_reg.idle;
    st_next.discard = drp_evt;
    if (accept_pkt) begin
      st_next.in_pkt = 1'b1;
    end
    if (last_beat) begin
      st_next.in_pkt = 1'b0;
    end

    // Shortfall: packet kept, engine simply waits for descriptors
    if (queue_drained && st_reg.in_pkt && !last_beat) begin
      st_next.shortfall = 1'b1;
    end
    if (last_beat) begin
      st_next.shortfall = 1'b0;
    end

    // Idle tracking; a resuming tail write beats a drain in the same cycle
    if (queue_drained) begin
      st_next.idle = 1'b1;
    end
    if (st_next.fetch) begin
      st_next.idle = 1'b0;
    end

    // Delay countdown
    tick = 1'b0;
    if (st_reg.dly_run) begin
      if (st_reg.pre == `DCS_DLY_TICK - 7'h01) begin
        st_next.pre = 7'h00;
        tick = 1'b1;
      end else begin
        st_next.pre = st_reg.pre + 7'h01;
      end
    end
    set = 5'h00;
    set[`DCS_F_ERR - `DCS_F_PEER] = error_event;
    set[`DCS_F_PEER - `DCS_F_PEER] = peer_error_event;
    if (tick) begin
      if (st_reg.dly_cnt == `DCS_CNT_ONE) begin
        // Timeout ends the run; next packet end starts it again
        st_next.dly_cnt = `DCS_CNT_ZERO;
        st_next.dly_run = 1'b0;
        set[`DCS_F_DLY - `DCS_F_PEER] = 1'b1;
      end else begin
        st_next.dly_cnt = st_reg.dly_cnt - 8'h01;
      end
    end
    if ((last_beat || (accept_pkt && st_reg.dly_run)) &&
        st_reg.ctrl[`DCS_F_CNT0_HI:`DCS_F_CNT0_LO] != `DCS_CNT_ZERO) begin
      st_next.dly_cnt = st_reg.ctrl[`DCS_F_CNT0_HI:`DCS_F_CNT0_LO];
      st_next.dly_run = 1'b1;
      st_next.pre = 7'h00;
    end

    // Completion threshold, end-of-frame descriptors only
    cmp_evt = desc_done && desc_eof;
    set[`DCS_F_CMP - `DCS_F_PEER] = cmp_evt;
    if (cmp_evt) begin
      if (st_reg.cmp_cnt <= `DCS_CNT_ONE) begin
        st_next.cmp_cnt = st_reg.ctrl[`DCS_F_CNT1_HI:`DCS_F_CNT1_LO];
        st_next.cmp_met = 1'b1;
      end else begin
        st_next.cmp_cnt = st_reg.cmp_cnt - 8'h01;
      end
    end

    // Drop threshold
    set[`DCS_F_DRP - `DCS_F_PEER] = drp_evt;
    if (drp_evt) begin
      if (st_reg.drp_cnt <= `DCS_CNT_ONE) begin
        st_next.drp_cnt = st_reg.ctrl[`DCS_F_CNT2_HI:`DCS_F_CNT2_LO];
        st_next.drp_met = 1'b1;
      end else begin
        st_next.drp_cnt = st_reg.drp_cnt - 8'h01;
      end
    end

    // Sticky flags: a new event outranks a clear in the same cycle
    st_next.flags = (st_reg.flags & ~clr) | set;
    if (clr[`DCS_F_CMP - `DCS_F_PEER] && !set[`DCS_F_CMP - `DCS_F_PEER]) begin
      st_next.cmp_met = 1'b0;
    end
    if (clr[`DCS_F_DRP - `DCS_F_PEER] && !set[`DCS_F_DRP - `DCS_F_PEER]) begin
      st_next.drp_met = 1'b0;
    end

    // Interrupt from flag and enable pairs
    st_next.irq =
      (st_reg.flags[`DCS_F_ERR - `DCS_F_PEER] && st_reg.ctrl[`DCS_F_ERR]) ||
      (st_reg.flags[`DCS_F_DLY - `DCS_F_PEER] && st_reg.ctrl[`DCS_F_DLY]) ||
      (st_reg.flags[`DCS_F_CMP - `DCS_F_PEER] && st_reg.ctrl[`DCS_F_CMP] &&
       st_reg.cmp_met) ||
      (st_reg.flags[`DCS_F_DRP - `DCS_F_PEER] && st_reg.ctrl[`DCS_F_DRP] &&
       st_reg.drp_met) ||
      (st_reg.flags[`DCS_F_PEER - `DCS_F_PEER] && st_reg.ctrl[`DCS_F_PEER]);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg           <= '0;
      st_reg.ctrl      <= `DCS_CTRL_RST;
      st_reg.dly_cnt   <= `DCS_CNT_ZERO;
      st_reg.cmp_cnt   <= `DCS_CNT_ONE;
      st_reg.drp_cnt   <= `DCS_CNT_ONE;
      st_reg.idle      <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready   = !st_reg.aw_hold;
  assign s_axi_wready    = !st_reg.w_hold;
  assign s_axi_bvalid    = st_reg.bvalid;
  assign s_axi_bresp     = st_reg.bresp;
  assign s_axi_arready   = !st_reg.rvalid;
  assign s_axi_rvalid    = st_reg.rvalid;
  assign s_axi_rdata     = st_reg.rdata;
  assign s_axi_rresp     = st_reg.rresp;
  assign channel_run_bit = st_reg.ctrl[`DCS_F_RUN];
  assign fetch_start     = st_reg.fetch;
  assign pkt_discard     = st_reg.discard;
  assign irq_out         = st_reg.irq;

endmodule
`default_nettype wire

// ===== src/dcs_map.svh
// Register map, field positions and reset values of the channel status block
// Function
// - Bits 31:24 show live delay countdown; reset zero.
// - Bits 23:16 show remaining completion threshold count; reset one.
// - Bits 15:8 show remaining drop threshold count; reset one.
// - Bit 7 sets on channel error; with its enable, drives interrupt.
// - Flags 7..3 clear on writing one; otherwise stay set.
// - Bit 6 sets on delay timer expiry; with its enable, drives interrupt.
// - Bit 5 sets only on completion of an end-of-frame descriptor.
// - Completion flag interrupts only when enabled and threshold reached zero.
// - Bit 4 sets on packet drop; interrupts when enabled and threshold exhausted.
// - Bit 3 sets on other-channel error; with its enable, drives interrupt.
// - Shortfall bit sets when queue empties mid-packet; packet kept, engine waits.
// - Shortfall may pulse on last descriptor; clears once final beat absorbed.
// - Idle bit one when tail reached and all finished; reset one.
// - Tail pointer write resumes fetching on an idle running channel.
// - Packets arriving while idle are discarded.
// - Delay countdown decrements once per 125 clock cycles.
// - Completion counter decrements per event; interrupt condition at zero.
// - Running delay countdown restarts on new packet or packet end; timeout stops it.
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define DCS_OFF_CTRL    4'h0
`define DCS_OFF_STATUS  4'h4
`define DCS_OFF_TAIL    4'h8
// ----------------------------------------
// Fields
// ----------------------------------------
`define DCS_F_CNT0_HI   31
`define DCS_F_CNT0_LO   24
`define DCS_F_CNT1_HI   23
`define DCS_F_CNT1_LO   16
`define DCS_F_CNT2_HI   15
`define DCS_F_CNT2_LO   8
`define DCS_F_ERR       7
`define DCS_F_DLY       6
`define DCS_F_CMP       5
`define DCS_F_DRP       4
`define DCS_F_PEER      3
`define DCS_F_RSV_HI    2
`define DCS_F_RSV_LO    1
`define DCS_F_SHORT     1
`define DCS_F_IDLE      0
`define DCS_F_RUN       0
`define DCS_TAIL_MASK   32'hFFFFFFC0
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define DCS_CTRL_RST    32'h00010100
`define DCS_CNT_ONE     8'h01
`define DCS_CNT_ZERO    8'h00
`define DCS_DLY_TICK    7'h7D
`define DCS_RESP_OKAY   2'h0
`define DCS_RESP_SLVERR 2'h2
`endif

// ===== src/dcs_pkg.sv
// Types of the channel status block
package dcs_pkg;
  typedef enum logic [3:0] {
    DCS_SEL_NONE   = 4'h1,
    DCS_SEL_CTRL   = 4'h2,
    DCS_SEL_STATUS = 4'h4,
    DCS_SEL_TAIL   = 4'h8
  } dcs_sel_e;

  typedef struct packed {
    logic        aw_hold;
    logic [3:0]  aw_addr;
    logic        w_hold;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] ctrl;
    logic [31:0] tail;
    logic [7:0]  dly_cnt;
    logic [7:0]  cmp_cnt;
    logic [7:0]  drp_cnt;
    logic [4:0]  flags;
    logic        shortfall;
    logic        idle;
    logic        in_pkt;
    logic        dly_run;
    logic [6:0]  pre;
    logic        cmp_met;
    logic        drp_met;
    logic        irq;
    logic        fetch;
    logic        discard;
  } dcs_state_s;
endpackage

// ===== tb/dcs_channel_status_chk.sv
// Port-level assertions for the channel status block
`timescale 1ns/1ps
`default_nettype none
module dcs_channel_status_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Engine side
  input wire logic        pkt_arrive,
  input wire logic        channel_run_bit,
  input wire logic        fetch_start,
  input wire logic        pkt_discard,
  input wire logic        irq_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_discard; pkt_discard |-> $past(pkt_arrive); endproperty
  a_discard: assert property (p_discard)
    else $error("discard without arriving packet");
  property p_fetch_run; fetch_start |-> channel_run_bit; endproperty
  a_fetch_run: assert property (p_fetch_run)
    else $error("fetch start while channel stopped");
  property p_fetch_pulse; fetch_start |=> !fetch_start; endproperty
  a_fetch_pulse: assert property (p_fetch_pulse)
    else $error("fetch start longer than one cycle");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before taken");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped before taken");
  property p_b_one; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_one: assert property (p_b_one)
    else $error("write response repeated after taken");
  property p_r_one; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_one: assert property (p_r_one)
    else $error("read data repeated after taken");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
  property p_w_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_w_lat: assert property (p_w_lat)
    else $error("write answer late");
  property p_aw_block; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("second address accepted while one held");
  property p_ar_rv; s_axi_arready == !s_axi_rvalid; endproperty
  a_ar_rv: assert property (p_ar_rv)
    else $error("read address ready while data pending");
  property p_rst; $rose(aresetn) |-> !irq_out && !channel_run_bit && !fetch_start; endproperty
  a_rst: assert property (p_rst)
    else $error("engine outputs active out of reset");
  c_fetch: cover property (fetch_start);
  c_discard: cover property (pkt_discard);
  c_irq: cover property ($rose(irq_out));
endmodule
`default_nettype wire

// ===== tb/dcs_channel_status_tb.sv
// Self-checking bench of the channel status block
`timescale 1ns/1ps
`default_nettype none
`include "dcs_map.svh"
module dcs_channel_status_tb;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [6:0]  ev;
    logic [31:0] st;
    logic        irq;
  } dcs_row_s;
  logic        aclk;
  logic        aresetn;
  logic [3:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [3:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [6:0]  ev;
  logic        run;
  logic        fetch;
  logic        discard;
  logic        irq;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          fail_count;
  int          checked;
  int          cyc;
  int          n_fetch;
  int          n_disc;
  dcs_row_s    rows [6];

  dcs_channel_status i_dcs_channel_status (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .error_event(ev[0]), .peer_error_event(ev[1]), .desc_done(ev[2]), .desc_eof(ev[3]),
    .pkt_arrive(ev[4]), .last_beat(ev[5]), .queue_drained(ev[6]),
    .channel_run_bit(run), .fetch_start(fetch), .pkt_discard(discard), .irq_out(irq)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Ready raised with the request; each side dropped at the edge that takes it
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta;
    logic tw;
    logic tb;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      rsp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask
  task automatic axr(input logic [3:0] a);
    logic ta;
    logic tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      rd = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end while (!tr);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    axr(a);
    chk(rd & m, exp);
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= 7'h00;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask
  // ----------------------------------------
  // Clock, monitors, sequence
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (fetch === 1'b1) n_fetch++;
    if (discard === 1'b1) n_disc++;
    if (cyc == 3000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    {aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, ev} = '0;
    {fail_count, checked, cyc, n_fetch, n_disc} = '0;
    rows = '{'{32'h00010180, 7'h01, 32'h00010181, 1'b1},
             '{32'h00010108, 7'h02, 32'h00010109, 1'b1},
             '{32'h00010120, 7'h04, 32'h00010101, 1'b0},
             '{32'h00010120, 7'h0C, 32'h00010121, 1'b1},
             '{32'h00010110, 7'h10, 32'h00010111, 1'b1},
             '{32'h00010100, 7'h01, 32'h00010181, 1'b0}};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({29'h0, run, irq, fetch}, 32'h0);
    rdc(`DCS_OFF_STATUS, 32'hFFFFFFFF, 32'h00010101);
    rdc(`DCS_OFF_CTRL, 32'hFFFFFFFF, `DCS_CTRL_RST);
    $display("test reset done");
    foreach (rows[i]) begin
      axw(`DCS_OFF_CTRL, rows[i].ctrl, 4'hF);
      pulse(rows[i].ev);
      chk({31'h0, irq}, {31'h0, rows[i].irq});
      axw(`DCS_OFF_STATUS, 32'h0, 4'hF);
      rdc(`DCS_OFF_STATUS, 32'hFFFFFFFF, rows[i].st);
      axw(`DCS_OFF_STATUS, 32'hF8, 4'hF);
      rdc(`DCS_OFF_STATUS, 32'hFFFFFFFF, 32'h00010101);
    end
    @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    chk(32'(n_disc), 32'h1);
    $display("test flags done");
    // Threshold three: first event reloads, then counts down
    axw(`DCS_OFF_CTRL, 32'h00030120, 4'hF);
    pulse(7'h0C);
    chk({31'h0, irq}, 32'h1);
    axw(`DCS_OFF_STATUS, 32'h20, 4'hF);
    pulse(7'h0C);
    chk({31'h0, irq}, 32'h0);
    axw(`DCS_OFF_STATUS, 32'hFFFFFF06, 4'hF);
    rdc(`DCS_OFF_STATUS, 32'hFFFFFFFF, 32'h00020121);
    pulse(7'h0C);
    rdc(`DCS_OFF_STATUS, 32'hFFFFFFFF, 32'h00010121);
    pulse(7'h0C);
    chk({31'h0, irq}, 32'h1);
    axw(`DCS_OFF_STATUS, 32'h20, 4'hE);
    rdc(`DCS_OFF_STATUS, 32'hFFFFFFFF, 32'h00030121);
    axw(`DCS_OFF_STATUS, 32'h20, 4'h1);
    $display("test threshold done");
    axw(`DCS_OFF_CTRL, 32'h00010101, 4'hF);
    @(negedge aclk);
    chk({31'h0, run}, 32'h1);
    axw(`DCS_OFF_TAIL, 32'h12345678, 4'hF);
    rdc(`DCS_OFF_STATUS, 32'hFF, 32'h00);
    axw(`DCS_OFF_TAIL, 32'h00000080, 4'hF);
    @(negedge aclk);
    chk(32'(n_fetch), 32'h1);
    rdc(`DCS_OFF_TAIL, 32'hFFFFFFFF, 32'h00000080);
    pulse(7'h10);
    pulse(7'h40);
    rdc(`DCS_OFF_STATUS, 32'hFF, 32'h03);
    chk(32'(n_disc), 32'h1);
    pulse(7'h20);
    rdc(`DCS_OFF_STATUS, 32'hFF, 32'h01);
    axw(`DCS_OFF_TAIL, 32'h00000100, 4'hF);
    @(negedge aclk);
    chk(32'(n_fetch), 32'h2);
    $display("test idle done");
    axw(`DCS_OFF_CTRL, 32'h02010141, 4'hF);
    pulse(7'h20);
    repeat (110) @(negedge aclk);
    rdc(`DCS_OFF_STATUS, 32'hFF000040, 32'h02000000);
    repeat (140) @(negedge aclk);
    rdc(`DCS_OFF_STATUS, 32'hFF000040, 32'h40);
    chk({31'h0, irq}, 32'h1);
    $display("test delay done");
    axw(4'hC, 32'hFFFFFFFF, 4'hF);
    chk({30'h0, rsp}, {30'h0, `DCS_RESP_SLVERR});
    rdc(4'hC, 32'hFFFFFFFF, 32'h0);
    chk({30'h0, rsp}, {30'h0, `DCS_RESP_SLVERR});
    $display("test unmapped done");
    // Reset in mid-run, with run bit and an interrupt active
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({29'h0, run, irq, fetch}, 32'h0);
    rdc(`DCS_OFF_STATUS, 32'hFFFFFFFF, 32'h00010101);
    rdc(`DCS_OFF_CTRL, 32'hFFFFFFFF, `DCS_CTRL_RST);
    $display("test reset again done");
    close_out();
  end
endmodule
bind dcs_channel_status dcs_channel_status_chk i_dcs_channel_status_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pkt_arrive(pkt_arrive), .channel_run_bit(channel_run_bit), .fetch_start(fetch_start),
  .pkt_discard(pkt_discard), .irq_out(irq_out)
);
`default_nettype wire
